// ---- logic/smsc_checker.sv ----
// coded operating mode selection checker: key insertion up to validated selection
// Behaviour
// - all codes are bytes from 1FH, E3H, FCH, mutually Hamming distance at least five
// - key authorization: automatic 1FH, setup E3H, service FCH; others invalid
// - panel selection: automatic E3H, setup FCH, service 1FH
// - check feedback: automatic 1FH, setup FCH, service E3H
// - switch byte: automatic E3H, setup 1FH, service FCH
// - modes are hierarchical; service permits setup and automatic too
// - key input starts about one second timeout; data must arrive before expiry
// - a marker holding any nonzero value means new data arrived
// - granted level must be a permitted code, else error mode
// - selected mode must lie within granted level after decoding both
// - chosen mode must be a permitted selection code, else error mode
// - one step per scan cycle, advance only after step completes
// - key checked before each step; removal returns to initial state
// - after the sequence the key check keeps running each scan
// - only this controller switches mode and enables safety equipment
// - zero is never a code; it marks a removed key
`timescale 1ns/1ps
module smsc_checker
  import smsc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYCLES,
  parameter int unsigned SCAN_CYC    = SCAN_CYCLES
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // key reader switching channel, asynchronous pin
  input  wire logic             safe_key_input,
  // marker words from the standard controller, same clock
  input  wire logic [7:0]       granted_level_marker,
  input  wire logic [7:0]       chosen_mode_marker,
  // results towards the standard controller and the machine
  output logic      [7:0]       check_feedback_byte,
  output logic      [1:0]       safe_operation_mode,
  output logic [NUM_MODES-1:0]  safety_enable,
  output logic                  error_mode,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // key input synchroniser

  logic key_s1_q;
  logic key_s2_q;
  logic key_s3_q;
  logic key_q;

  // three stages; the first is read only by the second
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      key_s3_q <= 1'b0;
    end
    else
    begin
      key_s1_q <= safe_key_input;
      key_s2_q <= key_s1_q;
      key_s3_q <= key_s2_q;
    end
  end

  // a change counts only once the two later stages agree
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      key_q <= 1'b0;
    else if (key_s2_q == key_s3_q)
      key_q <= key_s2_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and scan tick

  logic        run_q;
  logic        scan_tick;
  logic        step;
  smsc_state_e state_q;
  smsc_state_e state_d;

  // run enable written by software
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      run_q <= CTRL_RUN_RESET;
    else if (reg_wr && reg_addr == ADDR_CTRL)
      run_q <= reg_wdata[CTRL_RUN_BIT];
  end

  // scan cycle divider; the sequencer moves only on its tick
  smsc_cycle_counter #(
    .CYCLES (SCAN_CYC)
  ) u_scan (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .run     (run_q),
    .tick    (scan_tick)
  );

  assign step = scan_tick; // one step per scan

  ////////////////////////////////////////////////////////////////////////////
  // key insertion timeout

  logic timer_run;
  logic timer_tick;
  logic timeout_q;

  // runs from key insertion until the selection has been validated
  assign timer_run = key_q && (state_q != SMSC_DONE) && (state_q != SMSC_ERROR);

  smsc_cycle_counter #(
    .CYCLES (TIMEOUT_CYC)
  ) u_timeout (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .run     (timer_run),
    .tick    (timer_tick)
  );

  // sticky expiry, cleared only by key removal; expiry wins over the clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      timeout_q <= 1'b0;
    else if (timer_tick)
      timeout_q <= 1'b1;
    else if (!key_q)
      timeout_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  logic [7:0] level_byte_q;
  logic [7:0] choice_byte_q;
  logic [1:0] granted_lvl;
  logic [1:0] chosen_lvl;
  logic [2:0] fault_q;
  logic [2:0] fault_d;

  assign granted_lvl = smsc_level_of_auth(level_byte_q);
  assign chosen_lvl  = smsc_level_of_sel(choice_byte_q);

  // next step, evaluated once per scan
  always_comb
  begin
    state_d = state_q;
    fault_d = fault_q;
    if (!key_q)
    begin
      state_d = SMSC_IDLE; // key check ahead of every step
      fault_d = FAULT_NONE;
    end
    else if (state_q == SMSC_ERROR || state_q == SMSC_DONE)
    begin
      state_d = state_q; // hold until removal
    end
    else if (timeout_q && state_q != SMSC_IDLE)
    begin
      state_d = SMSC_ERROR;
      fault_d = FAULT_TIMEOUT;
    end
    else
    begin
      case (state_q)
        SMSC_IDLE:
          state_d = SMSC_WAIT_LEVEL;
        SMSC_WAIT_LEVEL:
          if (granted_level_marker != CODE_NONE)
            state_d = SMSC_WAIT_CHOICE;
        SMSC_WAIT_CHOICE:
          if (chosen_mode_marker != CODE_NONE)
            state_d = SMSC_CHK_LEVEL;
        SMSC_CHK_LEVEL:
          if (granted_lvl == LVL_NONE)
          begin
            state_d = SMSC_ERROR;
            fault_d = FAULT_LEVEL;
          end
          else
            state_d = SMSC_CHK_RANGE;
        SMSC_CHK_RANGE:
          // an invalid selection decodes to none and passes here, caught next
          if (chosen_lvl > granted_lvl)
          begin
            state_d = SMSC_ERROR; // higher level contains lower
            fault_d = FAULT_RANGE;
          end
          else
            state_d = SMSC_CHK_CHOICE;
        SMSC_CHK_CHOICE:
          if (chosen_lvl == LVL_NONE)
          begin
            state_d = SMSC_ERROR;
            fault_d = FAULT_CHOICE;
          end
          else
            state_d = SMSC_DONE;
        default:
          state_d = SMSC_ERROR;
      endcase
    end
  end

  // state and fault advance on the scan tick only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_q <= SMSC_IDLE;
      fault_q <= FAULT_NONE;
    end
    else if (step)
    begin
      state_q <= state_d;
      fault_q <= fault_d;
    end
  end

  // marker bytes are taken in the step that sees them nonzero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      level_byte_q  <= CODE_NONE;
      choice_byte_q <= CODE_NONE;
    end
    else if (step && state_q == SMSC_IDLE)
    begin
      level_byte_q  <= CODE_NONE;
      choice_byte_q <= CODE_NONE;
    end
    else if (step && key_q && state_q == SMSC_WAIT_LEVEL && state_d == SMSC_WAIT_CHOICE)
      level_byte_q <= granted_level_marker;
    else if (step && key_q && state_q == SMSC_WAIT_CHOICE && state_d == SMSC_CHK_LEVEL)
      choice_byte_q <= chosen_mode_marker;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode, feedback and safety equipment outputs

  logic [1:0] mode_q;

  // mode changes only on a fully validated selection; error keeps it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      mode_q <= LVL_NONE;
    else if (step && key_q && state_q == SMSC_CHK_CHOICE && state_d == SMSC_DONE)
      mode_q <= chosen_lvl;
  end

  // feedback only after all checks passed, cleared on removal or error
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      check_feedback_byte <= CODE_NONE;
    else if (step && state_d == SMSC_DONE && state_q == SMSC_CHK_CHOICE)
      check_feedback_byte <= smsc_feedback_of(chosen_lvl);
    else if (step && state_d != SMSC_DONE)
      check_feedback_byte <= CODE_NONE;
  end

  // error indication follows the sequencer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      error_mode <= 1'b0;
    else
      error_mode <= (state_q == SMSC_ERROR);
  end

  // one enable per mode, driven only by this controller
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MODES; gi++)
    begin : g_enable
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
          safety_enable[gi] <= 1'b0;
        else
          safety_enable[gi] <= (mode_q == 2'(gi + 1));
      end
    end
  endgenerate

  assign safe_operation_mode = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  logic [31:0] status_word;
  logic [31:0] codes_word;

  // status shows the sequencer's own state
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ST_STATE_LSB +: 4] = state_q;
    status_word[ST_ERROR_BIT]      = (state_q == SMSC_ERROR);
    status_word[ST_KEY_BIT]        = key_q;
    status_word[ST_TIMEOUT_BIT]    = timeout_q;
    status_word[ST_MODE_LSB +: 2]  = mode_q;
    status_word[ST_FAULT_LSB +: 3] = fault_q;
    codes_word = 32'h0000_0000;
    codes_word[CODES_LEVEL_LSB +: 8]  = level_byte_q;
    codes_word[CODES_CHOICE_LSB +: 8] = choice_byte_q;
    codes_word[CODES_FB_LSB +: 8]     = check_feedback_byte;
  end

  // read data stand for one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !reg_rd)
      reg_rdata <= 32'h0000_0000;
    else if (reg_addr == ADDR_CTRL)
      reg_rdata <= {31'h0000_0000, run_q};
    else if (reg_addr == ADDR_STATUS)
      reg_rdata <= status_word;
    else if (reg_addr == ADDR_CODES)
      reg_rdata <= codes_word;
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule // smsc_checker

// ---- logic/smsc_pkg.sv ----
// package: codes, register map, timing and states of the mode selection checker
package smsc_pkg;

  // timing
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned TIMEOUT_MS     = 1000;
  localparam int unsigned TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned SCAN_US        = 1000;
  localparam int unsigned SCAN_CYCLES    = (CLK_HZ / 1_000_000) * SCAN_US;
  localparam int unsigned CNT_W          = 27;

  // authorization codes carried by the key
  localparam logic [7:0] LEVEL_CODE_AUTOMATIC = 8'h1F;
  localparam logic [7:0] LEVEL_CODE_SETUP     = 8'hE3;
  localparam logic [7:0] LEVEL_CODE_SERVICE   = 8'hFC;
  // selection codes sent by the panel
  localparam logic [7:0] SELECTION_CODE_AUTOMATIC = 8'hE3;
  localparam logic [7:0] SELECTION_CODE_SETUP     = 8'hFC;
  localparam logic [7:0] SELECTION_CODE_SERVICE   = 8'h1F;
  // check feedback codes
  localparam logic [7:0] FEEDBACK_CODE_AUTOMATIC = 8'h1F;
  localparam logic [7:0] FEEDBACK_CODE_SETUP     = 8'hFC;
  localparam logic [7:0] FEEDBACK_CODE_SERVICE   = 8'hE3;
  // switch codes, expected from the later stage
  localparam logic [7:0] SWITCH_CODE_AUTOMATIC = 8'hE3;
  localparam logic [7:0] SWITCH_CODE_SETUP     = 8'h1F;
  localparam logic [7:0] SWITCH_CODE_SERVICE   = 8'hFC;
  localparam logic [7:0] CODE_NONE             = 8'h00;

  // internal mode levels, ordered so that a higher level contains the lower ones
  localparam logic [1:0] LVL_NONE      = 2'h0;
  localparam logic [1:0] LVL_AUTOMATIC = 2'h1;
  localparam logic [1:0] LVL_SETUP     = 2'h2;
  localparam logic [1:0] LVL_SERVICE   = 2'h3;
  localparam int unsigned NUM_MODES    = 3;

  // register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CODES  = 4'h8;
  localparam int unsigned CTRL_RUN_BIT     = 0;
  localparam logic        CTRL_RUN_RESET   = 1'b1;
  localparam int unsigned ST_STATE_LSB     = 0;
  localparam int unsigned ST_ERROR_BIT     = 4;
  localparam int unsigned ST_KEY_BIT       = 5;
  localparam int unsigned ST_TIMEOUT_BIT   = 6;
  localparam int unsigned ST_MODE_LSB      = 8;
  localparam int unsigned ST_FAULT_LSB     = 12;
  localparam int unsigned CODES_LEVEL_LSB  = 0;
  localparam int unsigned CODES_CHOICE_LSB = 8;
  localparam int unsigned CODES_FB_LSB     = 16;

  // fault causes reported in status
  localparam logic [2:0] FAULT_NONE    = 3'h0;
  localparam logic [2:0] FAULT_TIMEOUT = 3'h1;
  localparam logic [2:0] FAULT_LEVEL   = 3'h2;
  localparam logic [2:0] FAULT_RANGE   = 3'h3;
  localparam logic [2:0] FAULT_CHOICE  = 3'h4;

  typedef enum logic [3:0] {
    SMSC_IDLE        = 4'b0000,
    SMSC_WAIT_LEVEL  = 4'b0001,
    SMSC_WAIT_CHOICE = 4'b0010,
    SMSC_CHK_LEVEL   = 4'b0011,
    SMSC_CHK_RANGE   = 4'b0100,
    SMSC_CHK_CHOICE  = 4'b0101,
    SMSC_DONE        = 4'b0110,
    SMSC_ERROR       = 4'b0111
  } smsc_state_e;

  // authorization byte to level, none for any other value
  function automatic logic [1:0] smsc_level_of_auth(input logic [7:0] code);
    if (code == LEVEL_CODE_AUTOMATIC) return LVL_AUTOMATIC;
    else if (code == LEVEL_CODE_SETUP) return LVL_SETUP;
    else if (code == LEVEL_CODE_SERVICE) return LVL_SERVICE;
    else return LVL_NONE;
  endfunction

  // selection byte to level, none for any other value
  function automatic logic [1:0] smsc_level_of_sel(input logic [7:0] code);
    if (code == SELECTION_CODE_AUTOMATIC) return LVL_AUTOMATIC;
    else if (code == SELECTION_CODE_SETUP) return LVL_SETUP;
    else if (code == SELECTION_CODE_SERVICE) return LVL_SERVICE;
    else return LVL_NONE;
  endfunction

  // level to feedback byte
  function automatic logic [7:0] smsc_feedback_of(input logic [1:0] lvl);
    if (lvl == LVL_AUTOMATIC) return FEEDBACK_CODE_AUTOMATIC;
    else if (lvl == LVL_SETUP) return FEEDBACK_CODE_SETUP;
    else if (lvl == LVL_SERVICE) return FEEDBACK_CODE_SERVICE;
    else return CODE_NONE;
  endfunction

endpackage

// ---- logic/smsc_cycle_counter.sv ----
// free counter that pulses once per CYCLES clocks while run is high
`timescale 1ns/1ps
module smsc_cycle_counter
  import smsc_pkg::*;
#(
  parameter int unsigned CYCLES = SCAN_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  // one-cycle pulse at the end of each period
  output logic      tick
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] count_q;

  // dropping run restarts the period from zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !run)
      count_q <= '0;
    else if (count_q == LAST)
      count_q <= '0;
    else
      count_q <= count_q + CNT_W'(1);
  end

  assign tick = run && (count_q == LAST);

endmodule // smsc_cycle_counter

// ---- tb/smsc_checker_chk.sv ----
// checker: port-level assertions for the mode selection checker
`timescale 1ns/1ps
module smsc_checker_chk
  import smsc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYCLES,
  parameter int unsigned SCAN_CYC    = SCAN_CYCLES
) (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  // key pin and marker words
  input wire logic                 safe_key_input,
  input wire logic [7:0]           granted_level_marker,
  input wire logic [7:0]           chosen_mode_marker,
  // results
  input wire logic [7:0]           check_feedback_byte,
  input wire logic [1:0]           safe_operation_mode,
  input wire logic [NUM_MODES-1:0] safety_enable,
  input wire logic                 error_mode,
  // register port
  input wire logic [3:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata
);
  localparam int unsigned TO_LIM = TIMEOUT_CYC + 2 * SCAN_CYC + 8;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0]  auth_lvl;
  logic [1:0]  sel_lvl;
  logic [7:0]  fb_exp;
  logic [2:0]  en_exp;
  logic [31:0] wait_q;
  //////////////////////////////////////////////////////////////////////////////
  // own decoders, kept apart from the design's functions on purpose
  assign auth_lvl = (granted_level_marker == 8'h1F) ? 2'h1 :
                    (granted_level_marker == 8'hE3) ? 2'h2 :
                    (granted_level_marker == 8'hFC) ? 2'h3 : 2'h0;
  assign sel_lvl  = (chosen_mode_marker == 8'hE3) ? 2'h1 :
                    (chosen_mode_marker == 8'hFC) ? 2'h2 :
                    (chosen_mode_marker == 8'h1F) ? 2'h3 : 2'h0;
  assign fb_exp   = (safe_operation_mode == 2'h1) ? 8'h1F :
                    (safe_operation_mode == 2'h2) ? 8'hFC :
                    (safe_operation_mode == 2'h3) ? 8'hE3 : 8'h00;
  assign en_exp   = (safe_operation_mode == 2'h0) ? 3'h0 : 3'h1 << (safe_operation_mode - 2'h1);
  // cycles the key stood with no level data; a stuck sequencer shows up here
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !safe_key_input || granted_level_marker != 8'h00 || error_mode)
      wait_q <= 32'h0000_0000;
    else
      wait_q <= wait_q + 32'h0000_0001;
  end
  //////////////////////////////////////////////////////////////////////////////
  enable_follows_mode_a: assert property (safety_enable == $past(en_exp))
    else $error("safety enable does not match mode");
  error_no_feedback_a: assert property (error_mode |-> check_feedback_byte == 8'h00)
    else $error("feedback shown in error mode");
  feedback_code_a: assert property (check_feedback_byte != 8'h00 |-> check_feedback_byte == fb_exp)
    else $error("feedback code does not match mode");
  mode_needs_done_a: assert property ($changed(safe_operation_mode) |-> check_feedback_byte != 8'h00)
    else $error("mode changed without a passed check");
  range_passed_a: assert property ($rose(check_feedback_byte != 8'h00) |-> safe_operation_mode == sel_lvl && sel_lvl != 2'h0 && sel_lvl <= auth_lvl)
    else $error("mode outside granted level");
  done_until_removal_a: assert property ($fell(check_feedback_byte != 8'h00) |-> !safe_key_input)
    else $error("feedback cleared with key present");
  timeout_bound_a: assert property (wait_q < TO_LIM)
    else $error("no error after key timeout");
  read_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule // smsc_checker_chk

bind smsc_checker smsc_checker_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .SCAN_CYC(SCAN_CYC))
  smsc_checker_chk_inst (.ref_clk, .rst_n, .safe_key_input, .granted_level_marker,
  .chosen_mode_marker, .check_feedback_byte, .safe_operation_mode, .safety_enable,
  .error_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

// ---- tb/smsc_std_ctrl_model.sv ----
// standard controller model: key pin relay and marker words for the safety side
`timescale 1ns/1ps
module smsc_std_ctrl_model (
  // clock
  input wire logic        ref_clk,
  // scenario controls: key presence, codes and their delays
  input wire logic        key_in,
  input wire logic [7:0]  level_code,
  input wire logic [7:0]  choice_code,
  input wire logic [15:0] lvl_delay,
  input wire logic [15:0] ch_delay,
  // towards the safety controller
  output logic            safe_key_input,
  output logic [7:0]      granted_level_marker,
  output logic [7:0]      chosen_mode_marker
);
  logic [15:0] age_q;
  // data trail the key pin by a chosen delay, so prompt and slow relays both occur
  always_ff @(posedge ref_clk)
  begin
    if (!key_in)
    begin
      safe_key_input       <= 1'b0;
      granted_level_marker <= 8'h00; // zero marks a removed key
      chosen_mode_marker   <= 8'h00;
      age_q                <= 16'h0000;
    end
    else
    begin
      safe_key_input <= 1'b1; // any valid key, content ignored
      age_q          <= age_q + 16'h0001;
      // level sent once the key has stood lvl_delay cycles, copied unchanged
      if (age_q == lvl_delay)
        granted_level_marker <= level_code;
      // panel choice copied unchanged; a bad one is commanded by the bench
      if (age_q == ch_delay)
        chosen_mode_marker <= choice_code;
    end
  end
endmodule // smsc_std_ctrl_model

// ---- tb/smsc_checker_test.sv ----
// testbench: mode selection checker against the standard controller model
`timescale 1ns/1ps
module smsc_checker_test
  import smsc_pkg::*;
;
  logic                 ref_clk;
  logic                 rst_n;
  logic                 key_in;
  logic                 reg_wr;
  logic                 reg_rd;
  logic                 chk_rd;
  logic                 rd_seen = 1'b0;
  logic [7:0]           level_code;
  logic [7:0]           choice_code;
  logic [15:0]          lvl_delay;
  logic [15:0]          ch_delay;
  logic [3:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic [31:0]          reg_rdata;
  logic [31:0]          rd_val;
  logic [31:0]          rnd;
  logic                 safe_key_input;
  logic                 error_mode;
  logic [7:0]           granted_level_marker;
  logic [7:0]           chosen_mode_marker;
  logic [7:0]           check_feedback_byte;
  logic [1:0]           safe_operation_mode;
  logic [NUM_MODES-1:0] safety_enable;
  logic [1:0]           last_mode;
  logic [31:0]          exp_q[$];
  logic [31:0]          mask_q[$];
  logic [7:0]           auth_tab[3] = '{8'h1F, 8'hE3, 8'hFC};
  logic [7:0]           sel_tab[3]  = '{8'hE3, 8'hFC, 8'h1F};
  logic [7:0]           fb_tab[3]   = '{8'h1F, 8'hFC, 8'hE3};
  int                   errors      = 0;
  int                   num_checks  = 0;
  integer               seed        = 49401;
  //////////////////////////////////////////////////////////////////////////////
  smsc_checker #(.TIMEOUT_CYC(200), .SCAN_CYC(8)) smsc_checker_inst (.ref_clk, .rst_n,
    .safe_key_input, .granted_level_marker, .chosen_mode_marker, .check_feedback_byte,
    .safe_operation_mode, .safety_enable, .error_mode, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);
  smsc_std_ctrl_model smsc_std_ctrl_model_inst (.ref_clk, .key_in, .level_code,
    .choice_code, .lvl_delay, .ch_delay, .safe_key_input, .granted_level_marker,
    .chosen_mode_marker);
  // 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    errors += exp_q.size(); // a note never met counts as a mismatch
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic c);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    chk_rd   <= c;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    chk_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic expect_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    rd_reg(a, 1'b1);
  endtask
  // poll status, bounded; a stuck sequencer ends the run
  task automatic wait_state(input logic [3:0] s);
    int n;
    n = 0;
    rd_reg(ADDR_STATUS, 1'b0);
    while (rd_val[3:0] !== s && n < 300)
    begin
      rd_reg(ADDR_STATUS, 1'b0);
      n++;
    end
    if (n >= 300)
    begin
      check({28'h0, rd_val[3:0]}, {28'h0, s});
      end_of_test();
    end
  endtask
  function automatic logic [31:0] st_word(input logic [3:0] s, input logic [1:0] m,
                                          input logic [2:0] f, input logic k);
    return {17'h0, f, 2'h0, m, 2'h0, k, (s == 4'h7), s};
  endfunction
  task automatic run_seq(input logic [7:0] lv, input logic [7:0] ch, input logic [15:0] ld,
                         input logic [15:0] cd, input logic [3:0] st, input logic [2:0] f,
                         input logic [1:0] m, input logic [7:0] fb, input logic [31:0] cm);
    @(posedge ref_clk);
    level_code  <= lv;
    choice_code <= ch;
    lvl_delay   <= ld;
    ch_delay    <= cd;
    key_in      <= 1'b1;
    wait_state(st);
    expect_rd(ADDR_STATUS, st_word(st, m, f, 1'b1), 32'h0000_733F);
    expect_rd(ADDR_CODES, {8'h00, fb, ch, lv}, cm);
    check({30'h0, safe_operation_mode}, {30'h0, m});
    check({31'h0, error_mode}, {31'h0, st == 4'h7});
    check({29'h0, safety_enable}, (m == 2'h0) ? 32'h0 : 32'h1 << (m - 2'h1));
    @(posedge ref_clk);
    key_in <= 1'b0;
    wait_state(4'h0);
    expect_rd(ADDR_STATUS, st_word(4'h0, m, 3'h0, 1'b0), 32'h0000_733F);
    expect_rd(ADDR_CODES, 32'h0000_0000, 32'h00FF_0000);
    check({31'h0, error_mode}, 32'h0000_0000);
    last_mode = m;
    $display("sequence %h/%h ended", lv, ch);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // monitor: each checked read result meets the oldest note
  always @(posedge ref_clk)
  begin
    if (rd_seen && exp_q.size() > 0)
    begin
      check(reg_rdata & mask_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(mask_q.pop_front());
    end
    rd_seen <= reg_rd && chk_rd;
  end
  // hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    key_in = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chk_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    level_code = 8'h00;
    choice_code = 8'h00;
    lvl_delay = 16'h0000;
    ch_delay = 16'h0000;
    last_mode = 2'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    expect_rd(ADDR_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
    expect_rd(4'hC, 32'h0000_0000, 32'hFFFF_FFFF);
    rnd = $random(seed);
    wr_reg(ADDR_STATUS, rnd);
    wr_reg(ADDR_CODES, rnd);
    expect_rd(ADDR_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
    expect_rd(ADDR_CODES, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("reset and register test ended");
    // key pulled while waiting for the choice: back to idle, no error
    @(posedge ref_clk);
    level_code <= auth_tab[2];
    lvl_delay <= 16'h0000;
    ch_delay <= 16'h4000;
    key_in <= 1'b1;
    wait_state(4'h2);
    @(posedge ref_clk);
    key_in <= 1'b0;
    wait_state(4'h0);
    expect_rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_733F);
    $display("mid-sequence removal test ended");
    // every granted level against every selection, random relay delays for permitted pairs only
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 3; j++)
      begin
        rnd = $random(seed);
        if (j <= i)
          run_seq(auth_tab[i], sel_tab[j], {11'h0, rnd[4:0]}, {11'h0, rnd[4:0]} + {11'h0, rnd[12:8]},
                  4'h6, 3'h0, 2'(j + 1), fb_tab[j], 32'h00FF_FFFF);
        else
          run_seq(auth_tab[i], sel_tab[j], 16'h0004, 16'h0010, 4'h7, 3'h3, last_mode, 8'h00,
                  32'h00FF_FFFF);
      end
    do rnd = $random(seed); while (rnd[7:0] inside {8'h00, 8'h1F, 8'hE3, 8'hFC});
    run_seq(rnd[7:0], sel_tab[0], 16'h0002, 16'h0009, 4'h7, 3'h2, last_mode, 8'h00,
            32'h00FF_FFFF);
    do rnd = $random(seed); while (rnd[7:0] inside {8'h00, 8'h1F, 8'hE3, 8'hFC});
    run_seq(auth_tab[2], rnd[7:0], 16'h0002, 16'h0009, 4'h7, 3'h4, last_mode, 8'h00,
            32'h00FF_FFFF);
    run_seq(auth_tab[0], sel_tab[0], 16'h4000, 16'h4000, 4'h7, 3'h1, last_mode, 8'h00,
            32'h00FF_0000);
    // stopped scan: the sequencer must not step with the key present
    wr_reg(ADDR_CTRL, 32'h0000_0000);
    @(posedge ref_clk);
    key_in <= 1'b1;
    repeat (40) @(posedge ref_clk);
    expect_rd(ADDR_STATUS, st_word(4'h0, last_mode, 3'h0, 1'b1), 32'h0000_733F);
    @(posedge ref_clk);
    key_in <= 1'b0;
    repeat (8) @(posedge ref_clk);
    wr_reg(ADDR_CTRL, 32'h0000_0001);
    expect_rd(ADDR_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
    $display("stopped scan test ended");
    repeat (2) @(posedge ref_clk);
    end_of_test();
  end
endmodule // smsc_checker_test
